// ==== rtl/mpsp_pkg.sv ====
// Shared constants and types for the metering pump stroke pacer.
package mpsp_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1_000_000;
   localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
   localparam int GLITCH_MS = 25;
   localparam int GAP_MS = 50;
   localparam int SPM_MAX = 240;
   localparam int MS_PER_MIN = 60000;
   localparam int MIN_PERIOD_MS = MS_PER_MIN / SPM_MAX;
   localparam int STROKE_MS = 100;
   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_SLOW = 5'h04;
   localparam logic [4:0] OFS_FAST = 5'h08;
   localparam logic [4:0] OFS_STATUS = 5'h0c;
   localparam logic [4:0] OFS_COUNT = 5'h10;
   localparam logic [15:0] SLOW_RST = 16'h0fa0;
   localparam logic [15:0] FAST_RST = 16'h4e20;
   localparam logic [1:0] VAR_FIXED = 2'h0;
   localparam logic [1:0] VAR_KNOB = 2'h1;
   localparam logic [1:0] VAR_ANALOG = 2'h2;

   typedef struct packed {
      logic [1:0] variant;
      logic remote;
      logic power;
   } mpsp_ctrl_t;

   typedef struct packed {
      logic contact;
      logic low_level;
      logic remote_en;
      logic stroking;
      logic running;
   } mpsp_status_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_STROKE = 2'b10
   } mpsp_state_t;
endpackage : mpsp_pkg

// ==== rtl/mpsp_pacer.sv ====
// Stroke pacer: mode control, pulse qualification, rate pacing and register slave.
//
// Contract
// - Remote pulse mode: closures shorter than 25 ms never produce a stroke.
// - Remote pulse mode: pulses under 50 ms after the previous one are ignored.
// - Accepted pulses between 240 and 1200 per minute give 240 strokes per minute.
// - Accepted pulses slower than 240 per minute give one stroke each.
// - Contact closing starts a pulse, reopening ends it.
// - Remote mode: stopped while enable contact open, responsive only while closed.
// - Enable contact ignored in local mode, watched continuously in remote mode.
// - Each button press toggles local and remote; local is the initial mode.
// - After supply loss, power and mode states resume as before.
// - Indicator flashes green in local mode, yellow in remote mode.
// - Knobless variant strokes at maximum rate in local mode.
// - Knob variants stroke at the knob rate in local mode.
// - Analog variant remote: 20 mA gives maximum speed, 4 mA gives zero.
// - At or above fast level run at maximum, below slow level stop.
// - Indicator lit between strokes and dark during each stroke.
// - Knob maps to a rate whose lowest value is one stroke per minute.
// - Low chemical level lights the red indicator and stops stroking.
//
// The address map and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module mpsp_pacer #(
   parameter int MS_CYCLES = mpsp_pkg::MS_CYC,
   parameter logic [1:0] VARIANT = mpsp_pkg::VAR_KNOB
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_pulse_closed,
   input wire logic i_remote_closed,
   input wire logic i_low_level,
   input wire logic i_mode_button,
   input wire logic [7:0] i_knob,
   input wire logic [15:0] i_loop_ua,
   input wire logic [1:0] i_nv_state,
   input wire logic i_nv_valid,
   output logic [1:0] o_nv_state,
   output logic o_stroke,
   output logic o_led_green,
   output logic o_led_yellow,
   output logic o_led_red
);
   import mpsp_pkg::*;

   // Contact inputs are slow pins; each passes a two-stage synchroniser.
   logic [3:0] pin_raw;
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   assign pin_raw = {i_mode_button, i_low_level, i_remote_closed, i_pulse_closed};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         always_ff @(posedge i_mclk or negedge i_resetn) begin
            if (!i_resetn) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
            end else begin
               sync1_reg[gi] <= pin_raw[gi];
               sync2_reg[gi] <= sync1_reg[gi];
            end
         end
      end
   endgenerate
   wire pulse_s = sync2_reg[0];
   wire remote_en_s = sync2_reg[1];
   wire low_s = sync2_reg[2];
   wire button_s = sync2_reg[3];

   // Millisecond tick.
   logic [31:0] ms_cnt_reg;
   wire ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) ms_cnt_reg <= 32'h0;
      else ms_cnt_reg <= ms_tick ? 32'h0 : ms_cnt_reg + 32'h1;
   end

   // Control state; the saved copy is reloaded once after reset release.
   mpsp_ctrl_t ctrl_reg;
   mpsp_ctrl_t ctrl_next;
   logic load_reg;
   logic button_d_reg;
   logic [15:0] slow_reg;
   logic [15:0] fast_reg;
   logic [31:0] count_reg;
   wire button_press = button_s & ~button_d_reg;
   wire bus_req = i_avs_read | i_avs_write;
   logic ack_reg;
   wire bus_wr = i_avs_write & ack_reg;
   wire [31:0] be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                          {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
   wire [31:0] ctrl_wide = {28'h0, ctrl_reg};
   wire [31:0] ctrl_wr = (ctrl_wide & ~be_mask) | (i_avs_writedata & be_mask);
   wire [31:0] slow_wr = ({16'h0, slow_reg} & ~be_mask) | (i_avs_writedata & be_mask);
   wire [31:0] fast_wr = ({16'h0, fast_reg} & ~be_mask) | (i_avs_writedata & be_mask);
   wire sel_ctrl = (i_avs_address == OFS_CTRL);
   wire sel_slow = (i_avs_address == OFS_SLOW);
   wire sel_fast = (i_avs_address == OFS_FAST);

   always_comb begin
      ctrl_next = ctrl_reg;
      if (load_reg) begin
         ctrl_next.power = i_nv_valid ? i_nv_state[1] : 1'b1;
         ctrl_next.remote = i_nv_valid ? i_nv_state[0] : 1'b0;
      end else begin
         if (bus_wr && sel_ctrl) begin
            ctrl_next.power = ctrl_wr[0];
            ctrl_next.remote = ctrl_wr[1];
         end
         // A press in the same cycle as a write wins, so no press is lost.
         if (button_press) ctrl_next.remote = ~ctrl_next.remote;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_reg <= '{variant: 2'h0, remote: 1'b0, power: 1'b0};
         load_reg <= 1'b1;
         button_d_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         ctrl_reg.variant <= VARIANT;
         load_reg <= 1'b0;
         button_d_reg <= button_s;
      end
   end
   assign o_nv_state = {ctrl_reg.power, ctrl_reg.remote};

   // Run condition: the enable contact only matters in remote mode.
   wire run = ctrl_reg.power & ~load_reg & ~low_s
              & (~ctrl_reg.remote | remote_en_s);
   wire pulse_mode = ctrl_reg.remote & (ctrl_reg.variant != VAR_ANALOG);

   // Pulse qualification: width from closing, gap from last acceptance.
   logic [7:0] width_reg;
   logic [15:0] gap_reg;
   logic armed_reg;
   wire accept = pulse_mode & run & pulse_s & armed_reg
                 & (width_reg >= 8'(GLITCH_MS - 1)) & ms_tick
                 & (gap_reg >= 16'(GAP_MS));
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         width_reg <= 8'h0;
         gap_reg <= 16'hffff;
         armed_reg <= 1'b1;
      end else begin
         if (!pulse_s) width_reg <= 8'h0;
         else if (ms_tick && width_reg != 8'hff) width_reg <= width_reg + 8'h1;
         if (accept) gap_reg <= 16'h0;
         else if (ms_tick && gap_reg != 16'hffff) gap_reg <= gap_reg + 16'h1;
         // One stroke per closure; reopening re-arms the detector.
         if (!pulse_s) armed_reg <= 1'b1;
         else if (accept) armed_reg <= 1'b0;
      end
   end

   // Rate pacing by accumulating num per millisecond against den.
   wire [8:0] knob_spm = 9'h1 + 9'((16'(i_knob) * 16'(SPM_MAX)) >> 8);
   wire [15:0] span = fast_reg - slow_reg;
   wire [15:0] diff = i_loop_ua - slow_reg;
   logic [31:0] num;
   logic [31:0] den;
   always_comb begin
      den = 32'(MS_PER_MIN);
      num = 32'h0;
      if (!ctrl_reg.remote) begin
         if (ctrl_reg.variant == VAR_FIXED) num = den;
         else num = {23'h0, knob_spm};
      end else if (ctrl_reg.variant == VAR_ANALOG) begin
         den = 32'(span) * 32'(MS_PER_MIN);
         if (fast_reg <= slow_reg || i_loop_ua < slow_reg) num = 32'h0;
         else if (i_loop_ua >= fast_reg) num = den;
         else num = 32'(diff) * 32'(SPM_MAX);
      end
   end
   logic [31:0] acc_reg;
   wire [32:0] acc_sum = {1'b0, acc_reg} + {1'b0, num};
   wire rate_req = run & ~pulse_mode & ms_tick & (acc_sum >= {1'b0, den});
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) acc_reg <= 32'h0;
      else if (!run || pulse_mode) acc_reg <= 32'h0;
      else if (ms_tick) acc_reg <= rate_req ? 32'(acc_sum - {1'b0, den}) : acc_sum[31:0];
   end

   // Stroke engine; spacing of starts is held to the maximum rate.
   mpsp_state_t state_reg;
   logic pend_reg;
   logic [15:0] since_reg;
   logic [7:0] stroke_ms_reg;
   wire ready = (since_reg >= 16'(MIN_PERIOD_MS)) & (state_reg == ST_IDLE);
   wire fire = pend_reg & run & ready;
   wire stroke_end = (state_reg == ST_STROKE) & ms_tick
                     & (stroke_ms_reg == 8'(STROKE_MS - 1));
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_reg <= ST_IDLE;
         pend_reg <= 1'b0;
         since_reg <= 16'hffff;
         stroke_ms_reg <= 8'h0;
      end else begin
         // A new request beats the clear; surplus pulses merge into one.
         pend_reg <= run & (accept | rate_req | (pend_reg & ~fire));
         if (fire) since_reg <= 16'h0;
         else if (ms_tick && since_reg != 16'hffff) since_reg <= since_reg + 16'h1;
         unique case (state_reg)
            ST_IDLE: begin
               stroke_ms_reg <= 8'h0;
               if (fire) state_reg <= ST_STROKE;
            end
            ST_STROKE: begin
               if (ms_tick) stroke_ms_reg <= stroke_ms_reg + 8'h1;
               if (stroke_end) state_reg <= ST_IDLE;
            end
         endcase
      end
   end
   wire stroking = (state_reg == ST_STROKE);
   assign o_stroke = stroking;

   // The gap helpers count raw cycles, so a slip in the millisecond counters still shows.
   logic [31:0] acc_gap_reg;
   logic [31:0] fire_gap_reg;
   logic acc_seen_reg;
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         acc_gap_reg <= 32'hffffffff;
         fire_gap_reg <= 32'hffffffff;
         acc_seen_reg <= 1'b0;
      end else begin
         if (accept) acc_gap_reg <= 32'h1;
         else if (acc_gap_reg != 32'hffffffff) acc_gap_reg <= acc_gap_reg + 32'h1;
         if (fire) fire_gap_reg <= 32'h1;
         else if (fire_gap_reg != 32'hffffffff) fire_gap_reg <= fire_gap_reg + 32'h1;
         if (!pulse_s) acc_seen_reg <= 1'b0;
         else if (accept) acc_seen_reg <= 1'b1;
      end
   end

   // Indicators: green/yellow lit between strokes while running, colour by mode; red follows low level.
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_led_green <= 1'b0;
         o_led_yellow <= 1'b0;
         o_led_red <= 1'b0;
      end else begin
         o_led_green <= run & ~stroking & ~ctrl_reg.remote;
         o_led_yellow <= run & ~stroking & ctrl_reg.remote;
         o_led_red <= low_s;
      end
   end

   // Avalon slave: every access waits exactly one cycle.
   mpsp_status_t status;
   assign status = '{contact: pulse_s, low_level: low_s, remote_en: remote_en_s,
                     stroking: stroking, running: run};
   wire [31:0] rd_mux = sel_ctrl ? ctrl_wide :
                        sel_slow ? {16'h0, slow_reg} :
                        sel_fast ? {16'h0, fast_reg} :
                        (i_avs_address == OFS_STATUS) ? {27'h0, status} :
                        (i_avs_address == OFS_COUNT) ? count_reg : 32'h0;
   assign o_avs_waitrequest = bus_req & ~ack_reg;
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         ack_reg <= 1'b0;
         o_avs_readdata <= 32'h0;
         slow_reg <= SLOW_RST;
         fast_reg <= FAST_RST;
         count_reg <= 32'h0;
      end else begin
         ack_reg <= bus_req & ~ack_reg;
         if (i_avs_read && !ack_reg) o_avs_readdata <= rd_mux;
         if (bus_wr && sel_slow) slow_reg <= slow_wr[15:0];
         if (bus_wr && sel_fast) fast_reg <= fast_wr[15:0];
         if (fire) count_reg <= count_reg + 32'h1;
      end
   end

   property p_glitch;
      @(posedge i_mclk) disable iff (!i_resetn)
      accept |-> pulse_s && $past(pulse_s, 2) && width_reg >= 8'(GLITCH_MS - 1);
   endproperty
   a_glitch: assert property (p_glitch) else $error("short closure accepted");

   property p_gap;
      @(posedge i_mclk) disable iff (!i_resetn)
      accept |-> acc_gap_reg >= 32'(GAP_MS * MS_CYCLES);
   endproperty
   a_gap: assert property (p_gap) else $error("pulses accepted too close");

   property p_cap;
      @(posedge i_mclk) disable iff (!i_resetn)
      fire |-> fire_gap_reg >= 32'(MIN_PERIOD_MS * MS_CYCLES) && !stroking;
   endproperty
   a_cap: assert property (p_cap) else $error("stroke rate above cap");

   property p_follow;
      @(posedge i_mclk) disable iff (!i_resetn)
      accept && ready && run |=> pend_reg ##1 (stroking || !$past(run));
   endproperty
   a_follow: assert property (p_follow) else $error("accepted pulse lost");

   property p_edge;
      @(posedge i_mclk) disable iff (!i_resetn)
      accept |-> !acc_seen_reg;
   endproperty
   a_edge: assert property (p_edge) else $error("second stroke in one closure");

   property p_remote_off;
      @(posedge i_mclk) disable iff (!i_resetn)
      ctrl_reg.remote && !remote_en_s |-> !fire && !rate_req && !accept;
   endproperty
   a_remote_off: assert property (p_remote_off) else $error("ran with enable open");

   property p_local_ignore;
      @(posedge i_mclk) disable iff (!i_resetn)
      !ctrl_reg.remote && ctrl_reg.power && !low_s && !load_reg |-> run;
   endproperty
   a_local_ignore: assert property (p_local_ignore) else $error("local mode gated");

   property p_toggle;
      @(posedge i_mclk) disable iff (!i_resetn)
      button_press && !load_reg && !(bus_wr && sel_ctrl)
         |=> ctrl_reg.remote != $past(ctrl_reg.remote);
   endproperty
   a_toggle: assert property (p_toggle) else $error("press did not toggle mode");

   property p_led;
      @(posedge i_mclk) disable iff (!i_resetn)
      (o_led_green || o_led_yellow) |-> !$past(stroking) && !(o_led_green && o_led_yellow);
   endproperty
   a_led: assert property (p_led) else $error("indicator lit during stroke");

   property p_low;
      @(posedge i_mclk) disable iff (!i_resetn)
      low_s |-> !fire ##1 o_led_red;
   endproperty
   a_low: assert property (p_low) else $error("low level not honoured");
endmodule : mpsp_pacer

// ==== verif/mpsp_contact_model.sv ====
// Partner model of the external pulse contact and the remote enable contact.
`timescale 1ns/1ps
module mpsp_contact_model #(
   parameter int MS_CYCLES = 10
) (
   input wire logic i_mclk,
   output logic o_pulse_closed,
   output logic o_remote_closed
);
   initial begin
      o_pulse_closed = 1'b0;
      o_remote_closed = 1'b0;
   end

   // Widths under 25 ms and gaps under 50 ms are asked for only where refusal is wanted.
   task automatic pulse(input int w_ms, input int g_ms);
      @(posedge i_mclk);
      o_pulse_closed <= 1'b1;
      repeat (w_ms * MS_CYCLES) @(posedge i_mclk);
      o_pulse_closed <= 1'b0;
      repeat (g_ms * MS_CYCLES) @(posedge i_mclk);
   endtask : pulse

   task automatic enable(input logic closed);
      @(posedge i_mclk);
      o_remote_closed <= closed;
   endtask : enable
endmodule : mpsp_contact_model

// ==== verif/metering_pump_stroke_pacer_tb_top.sv ====
// Self-checking testbench for the stroke pacer.
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin bad_count++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module metering_pump_stroke_pacer_tb_top;
   import mpsp_pkg::*;
   localparam int MS = 10;
   logic i_mclk = 1'b0;
   logic i_resetn = 1'b0;
   logic [4:0] i_avs_address = 5'h00;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest;
   logic i_low_level = 1'b0;
   logic i_mode_button = 1'b0;
   logic [7:0] i_knob = 8'hff;
   logic [1:0] i_nv_state = 2'h0;
   logic i_nv_valid = 1'b0;
   logic [1:0] o_nv_state;
   logic pulse_w, remote_w;
   logic o_stroke, o_led_green, o_led_yellow, o_led_red;
   logic stk_d = 1'b0;
   logic [31:0] rdv;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   int nstk = 0;
   int rise_cyc = 0;
   int n0, t0;
   logic [15:0] an_ua = 16'h0000;
   logic an_stroke;
   logic an_d = 1'b0;
   logic an_done = 1'b0;
   int an_n = 0;
   int a0;

   initial begin
      forever #5 i_mclk = ~i_mclk;
   end

   mpsp_pacer #(.MS_CYCLES(MS), .VARIANT(VAR_KNOB)) mpsp_pacer_i (
      .i_mclk(i_mclk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(4'hf), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_pulse_closed(pulse_w),
      .i_remote_closed(remote_w), .i_low_level(i_low_level), .i_mode_button(i_mode_button),
      .i_knob(i_knob), .i_loop_ua(16'h0000), .i_nv_state(i_nv_state),
      .i_nv_valid(i_nv_valid), .o_nv_state(o_nv_state), .o_stroke(o_stroke),
      .o_led_green(o_led_green), .o_led_yellow(o_led_yellow), .o_led_red(o_led_red));

   mpsp_contact_model #(.MS_CYCLES(MS)) mpsp_contact_model_i (
      .i_mclk(i_mclk), .o_pulse_closed(pulse_w), .o_remote_closed(remote_w));

   // A second pacer paced by the current loop; its saved state starts it in remote mode.
   if (1) begin : g_analog
      mpsp_pacer #(.MS_CYCLES(MS), .VARIANT(VAR_ANALOG)) mpsp_pacer_i (
         .i_mclk(i_mclk), .i_resetn(i_resetn), .i_avs_address(5'h00), .i_avs_read(1'b0),
         .i_avs_write(1'b0), .i_avs_writedata(32'h0), .i_avs_byteenable(4'hf),
         .o_avs_readdata(), .o_avs_waitrequest(), .i_pulse_closed(1'b0),
         .i_remote_closed(1'b1), .i_low_level(i_low_level), .i_mode_button(1'b0),
         .i_knob(i_knob), .i_loop_ua(an_ua), .i_nv_state(2'h3), .i_nv_valid(1'b1),
         .o_nv_state(), .o_stroke(an_stroke), .o_led_green(), .o_led_yellow(),
         .o_led_red());
   end

   always @(posedge i_mclk) begin
      if (an_stroke && !an_d) an_n++;
      an_d = an_stroke;
   end

   // Stroke starts must sit at least 250 ms apart, whatever the pulse rate.
   always @(posedge i_mclk) begin
      cyc++;
      if (i_resetn && o_stroke && !stk_d) begin
         if (nstk > 0) `CHK(cyc - rise_cyc >= 250 * MS, 1'b1)
         nstk++;
         rise_cyc = cyc;
      end
      // A stroke starts two cycles after a millisecond tick and ends on a tick.
      if (i_resetn && !o_stroke && stk_d) `CHK(cyc - rise_cyc, STROKE_MS * MS - 1)
      if (o_stroke && stk_d) `CHK({o_led_green, o_led_yellow}, 2'b00)
      stk_d = o_stroke;
   end

   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge i_mclk);
      i_avs_address <= a;
      i_avs_writedata <= wd;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      do begin
         @(posedge i_mclk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) begin
         `CHK(1'b0, 1'b1)
         results();
      end
      rdv = o_avs_readdata;
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
   endtask : bus

   task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      `CHK(rdv, exp)
   endtask : rchk

   task automatic do_reset();
      i_resetn <= 1'b0;
      repeat (16) @(posedge i_mclk);
      i_resetn <= 1'b1;
      repeat (4) @(posedge i_mclk);
   endtask : do_reset

   task automatic press();
      @(posedge i_mclk);
      i_mode_button <= 1'b1;
      repeat (50) @(posedge i_mclk);
      i_mode_button <= 1'b0;
      repeat (50) @(posedge i_mclk);
   endtask : press

   // Waits through one whole stroke so the indicator is looked at between strokes.
   task automatic between();
      int n;
      n = 0;
      while (o_stroke !== 1'b1 && n < 4000) begin
         @(posedge i_mclk);
         n++;
      end
      `CHK(o_stroke, 1'b1)
      while (o_stroke !== 1'b0 && n < 8000) begin
         @(posedge i_mclk);
         n++;
      end
      repeat (10) @(posedge i_mclk);
   endtask : between

   task automatic done(input string name);
      $display("test %s done", name);
   endtask : done

   task automatic results();
      $display("counts: checked=%0d bad_count=%0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   initial begin
      repeat (90000) @(posedge i_mclk);
      bad_count++;
      results();
   end

   // Current-loop pacing runs beside the pulse tests and ends before the low-level test.
   initial begin
      @(posedge i_resetn);
      repeat (5000) @(posedge i_mclk);
      `CHK(an_n, 0)
      an_ua <= FAST_RST;
      a0 = an_n;
      repeat (10000) @(posedge i_mclk);
      `CHK(an_n - a0 inside {[4:5]}, 1'b1)
      an_ua <= 16'h2ee0;
      repeat (2500) @(posedge i_mclk);
      a0 = an_n;
      repeat (10000) @(posedge i_mclk);
      `CHK(an_n - a0, 2)
      done("analog");
      an_done <= 1'b1;
   end

   initial begin
      do_reset();
      rchk(OFS_CTRL, {28'h0, VAR_KNOB, 2'b01});
      rchk(OFS_SLOW, {16'h0, SLOW_RST});
      rchk(OFS_FAST, {16'h0, FAST_RST});
      rchk(5'h14, 32'h0);
      bus(1'b1, OFS_SLOW, 32'h1234);
      rchk(OFS_SLOW, 32'h1234);
      `CHK(o_nv_state, 2'b10)
      done("registers");
      between();
      `CHK({o_led_green, o_led_yellow}, 2'b10)
      n0 = nstk;
      repeat (10000) @(posedge i_mclk);
      `CHK(nstk - n0 inside {[3:5]}, 1'b1)
      done("local");
      press();
      rchk(OFS_CTRL, {28'h0, VAR_KNOB, 2'b11});
      `CHK(o_nv_state, 2'b11)
      repeat (3000) @(posedge i_mclk);
      n0 = nstk;
      repeat (5) mpsp_contact_model_i.pulse(30, 70);
      `CHK(nstk - n0, 0)
      done("remote_disabled");
      mpsp_contact_model_i.enable(1'b1);
      repeat (1000) @(posedge i_mclk);
      mpsp_contact_model_i.pulse(20, 300);
      `CHK(nstk - n0, 0)
      t0 = cyc;
      mpsp_contact_model_i.pulse(30, 600);
      `CHK(nstk - n0, 1)
      `CHK(rise_cyc - t0 inside {[230:300]}, 1'b1)
      `CHK({o_led_green, o_led_yellow}, 2'b01)
      done("qualify");
      n0 = nstk;
      mpsp_contact_model_i.pulse(30, 10);
      mpsp_contact_model_i.pulse(30, 600);
      `CHK(nstk - n0, 1)
      n0 = nstk;
      repeat (10) mpsp_contact_model_i.pulse(30, 70);
      repeat (3000) @(posedge i_mclk);
      `CHK(nstk - n0 inside {[3:5]}, 1'b1)
      n0 = nstk;
      repeat (2) mpsp_contact_model_i.pulse(30, 470);
      `CHK(nstk - n0, 2)
      rchk(OFS_STATUS, 32'h00000005);
      rchk(OFS_COUNT, 32'(nstk));
      done("pacing");
      i_low_level <= 1'b1;
      repeat (100) @(posedge i_mclk);
      `CHK(o_led_red, 1'b1)
      n0 = nstk;
      mpsp_contact_model_i.pulse(30, 300);
      `CHK(nstk - n0, 0)
      i_low_level <= 1'b0;
      repeat (100) @(posedge i_mclk);
      `CHK(o_led_red, 1'b0)
      done("low_level");
      i_nv_state <= o_nv_state;
      i_nv_valid <= 1'b1;
      do_reset();
      rchk(OFS_CTRL, {28'h0, VAR_KNOB, 2'b11});
      done("restore");
      `CHK(an_done, 1'b1)
      results();
   end
endmodule : metering_pump_stroke_pacer_tb_top
